// *** logic/abg_map.vh ***
// constants for the converter board host glue
// How it works
// (R1) converter flags input beyond either full scale
// (R2) flag sets hold flop lighting range lamp
// (R3) jumper picks button or host write clear
// (R4) default jumper: button clears latch and converter
// (R5) low sync resets converter without modulator clock
// (R6) in reset: state cleared, data low, ready high
// (R7) host jumper: host makes sync pulse itself
// (R8) polarity jumper passes or inverts ready signal
// (R9) two jumpers choose one of four bases
// (R10) select needs both lines matched and enable
// (R11) fitted jumper expects 0, absent expects 1
// (R12) select plus read is read, plus write resets
// (R13) host enable marks valid access, undecoded
// (R14) jumper codes give offsets 0x0 to 0xc
// (R15) sixteen bit word, bit 0 least significant
// (R16) decoded write holds sync low during strobe (here sync goes low one clock later and stays low as many cycles as the strobe)
`ifndef ABG_MAP_VH
`define ABG_MAP_VH

// ------------------------------------------------------------
// register map, byte addresses
// ------------------------------------------------------------
`define ABG_ADDR_W        4
`define ABG_REG_STATUS    4'h0
`define ABG_REG_MASK      4'h4
`define ABG_REG_SAMPLE    4'h8
`define ABG_REG_CONTROL   4'hc

// ------------------------------------------------------------
// status and mask bit positions
// ------------------------------------------------------------
`define ABG_EV_RANGE      0
`define ABG_EV_READY      1
`define ABG_EV_HOSTRST    2
`define ABG_EV_W          3
`define ABG_MASK_RESET    3'h0

// control bit positions and reset value
`define ABG_CTL_LAMPCLR   0
`define ABG_CTL_FORCERST  1
`define ABG_CTL_RESET     2'h0

// ------------------------------------------------------------
// data and timing
// ------------------------------------------------------------
`define ABG_DATA_W        16
`define ABG_IN_W          18
`define ABG_FS_POS        18'sh07fff
`define ABG_FS_NEG        18'sh38001
`define ABG_CLK_NS        100
`define ABG_SAMPLE_NS     100
`define ABG_SAMPLE_CYC    ((`ABG_SAMPLE_NS + `ABG_CLK_NS - 1) / `ABG_CLK_NS)
`define ABG_OFFSET_STEP   4

`endif

// *** logic/abg_addr_decode.v ***
// base address decoder for the host select
`timescale 1ns/100ps
module abg_addr_decode (
   input  wire       addr_a2,
   input  wire       addr_a3,
   input  wire       host_space_enable,
   input  wire [1:0] base_select_jumpers,
   output wire       select
);
   // a fitted jumper (1) expects the line low, an open one high
   wire exp_a2;
   wire exp_a3;
   assign exp_a2 = ~base_select_jumpers[0]; // R11
   assign exp_a3 = ~base_select_jumpers[1]; // R11
   // both lines and the valid-access enable must agree
   assign select = host_space_enable &
                   (addr_a2 == exp_a2) &
                   (addr_a3 == exp_a3); // R10 R13
endmodule

// *** logic/abg_converter.v ***
// digital side of the converter: range flag, data word, ready
`timescale 1ns/100ps
`include "abg_map.vh"
module abg_converter #(
   parameter IN_W   = `ABG_IN_W,
   parameter DATA_W = `ABG_DATA_W,
   parameter PERIOD = `ABG_SAMPLE_CYC
) (
   input  wire                     clk,
   input  wire                     sys_rst,
   input  wire                     sync_n,
   input  wire signed [IN_W-1:0]   analog_code,
   output reg                      out_of_range_flag,
   output reg  [DATA_W-1:0]        sample_word,
   output reg                      conversion_ready
);
   wire conv_rst;
   wire above;
   wire below;
   reg  [7:0] div_reg;
   // sync low is an asynchronous reset, no clock edge needed
   assign conv_rst = sys_rst | ~sync_n; // R5
   assign above = analog_code > `ABG_FS_POS;
   assign below = analog_code < `ABG_FS_NEG;

   always @(posedge clk or posedge conv_rst) begin
      if (conv_rst) begin
         out_of_range_flag <= 1'b0; // R6
         sample_word       <= {DATA_W{1'b0}}; // R6
         conversion_ready  <= 1'b1; // R6
         div_reg           <= 8'h00;
      end else begin
         out_of_range_flag <= above | below; // R1
         if (div_reg == PERIOD[7:0] - 8'h01) begin
            div_reg <= 8'h00;
            // clamp to the word range; bit 0 is the lsb
            if (above)
               sample_word <= {1'b0, {(DATA_W-1){1'b1}}}; // R15
            else if (below)
               sample_word <= {1'b1, {(DATA_W-1){1'b0}}}; // R15
            else
               sample_word <= analog_code[DATA_W-1:0]; // R15
            conversion_ready <= 1'b0;
         end else begin
            div_reg          <= div_reg + 8'h01;
            conversion_ready <= 1'b1;
         end
      end
   end
endmodule

// *** logic/abg_board_glue.v ***
// host glue: range lamp, converter reset, ready polarity, decode
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "abg_map.vh"
module abg_board_glue #(
   parameter IN_W   = `ABG_IN_W,
   parameter DATA_W = `ABG_DATA_W,
   parameter PERIOD = `ABG_SAMPLE_CYC
) (
   input  wire                   clk,
   input  wire                   sys_rst,
   // converter analog side, as a signed code
   input  wire signed [IN_W-1:0] analog_code,
   // board jumpers and button
   input  wire                   reset_source_jumper,
   input  wire                   ready_polarity_jumper,
   input  wire [1:0]             base_select_jumpers,
   input  wire                   manual_reset_button,
   // host memory bus
   input  wire                   host_addr_a2,
   input  wire                   host_addr_a3,
   input  wire                   host_space_enable,
   input  wire                   host_rd,
   input  wire                   host_wr,
   // register port
   input  wire [3:0]             reg_addr,
   input  wire [31:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [31:0]            reg_rdata,
   // outputs
   output reg  [DATA_W-1:0]      sample_data,
   output reg                    host_read_cycle,
   output reg                    range_indicator_lamp,
   output reg                    ready_interrupt_out,
   output reg                    converter_sync_n,
   output reg                    irq
);

   // ------------------------------------------------------------
   // internal signals
   // ------------------------------------------------------------
   wire                  host_select;
   wire                  host_rd_cycle;
   wire                  host_wr_cycle;
   wire                  conv_oor;
   wire [DATA_W-1:0]     conv_word;
   wire                  conv_ready;
   wire                  reset_request;
   wire                  lamp_clear;
   wire [`ABG_EV_W-1:0]  ev_set;
   wire [`ABG_EV_W-1:0]  ev_clear;
   reg                   range_hold_flipflop;
   reg                   range_hold_next;
   reg                   sync_n_next;
   reg                   oor_prev_reg;
   reg                   ready_prev_reg;
   reg                   wr_prev_reg;
   reg  [`ABG_EV_W-1:0]  status_reg;
   reg  [`ABG_EV_W-1:0]  status_next;
   reg  [`ABG_EV_W-1:0]  mask_reg;
   reg  [1:0]            control_reg;
   reg  [15:0]           sample_count_reg;
   reg  [31:0]           rdata_next;

   // ------------------------------------------------------------
   // address decode and strobe qualification
   // ------------------------------------------------------------
   abg_addr_decode u_decode (
      .addr_a2             (host_addr_a2),
      .addr_a3             (host_addr_a3),
      .host_space_enable   (host_space_enable),
      .base_select_jumpers (base_select_jumpers),
      .select              (host_select)
   ); // R9 R14

   assign host_rd_cycle = host_select & host_rd; // R12
   assign host_wr_cycle = host_select & host_wr; // R12

   // ------------------------------------------------------------
   // converter
   // ------------------------------------------------------------
   abg_converter #(
      .IN_W   (IN_W),
      .DATA_W (DATA_W),
      .PERIOD (PERIOD)
   ) u_conv (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .sync_n            (converter_sync_n),
      .analog_code       (analog_code),
      .out_of_range_flag (conv_oor),
      .sample_word       (conv_word),
      .conversion_ready  (conv_ready)
   );

   // ------------------------------------------------------------
   // reset source selection
   // ------------------------------------------------------------
   // jumper low is the factory position: the button drives reset;
   // jumper high hands the job to a decoded host write, which then
   // holds sync low, one clock later, for as many cycles as its strobe stays high
   assign reset_request = reset_source_jumper ? host_wr_cycle
                                              : manual_reset_button; // R3 R4 R7 R16

   // software may also force the converter into reset
   always @* begin
      sync_n_next = ~(reset_request |
                      control_reg[`ABG_CTL_FORCERST]); // R5 R16
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         converter_sync_n <= 1'b0;
      else
         converter_sync_n <= sync_n_next;
   end

   // ------------------------------------------------------------
   // range latch and lamp
   // ------------------------------------------------------------
   // the same request that resets the converter clears the latch
   assign lamp_clear = reset_request |
                       control_reg[`ABG_CTL_LAMPCLR]; // R3 R4

   always @* begin
      range_hold_next = range_hold_flipflop;
      if (lamp_clear)
         range_hold_next = 1'b0; // R2
      // a flag seen in the clearing cycle still lights the lamp
      if (conv_oor)
         range_hold_next = 1'b1; // R2
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         range_hold_flipflop  <= 1'b0;
         range_indicator_lamp <= 1'b0;
      end else begin
         range_hold_flipflop  <= range_hold_next;
         range_indicator_lamp <= range_hold_next; // R2
      end
   end

   // ------------------------------------------------------------
   // ready polarity and data output
   // ------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_interrupt_out <= 1'b1;
         sample_data         <= {DATA_W{1'b0}};
         host_read_cycle     <= 1'b0;
      end else begin
         ready_interrupt_out <= conv_ready ^ ready_polarity_jumper; // R8
         sample_data         <= conv_word; // R15
         host_read_cycle     <= host_rd_cycle; // R12
      end
   end

   // ------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         oor_prev_reg     <= 1'b0;
         ready_prev_reg   <= 1'b1;
         wr_prev_reg      <= 1'b0;
         sample_count_reg <= 16'h0000;
      end else begin
         oor_prev_reg   <= conv_oor;
         ready_prev_reg <= conv_ready;
         wr_prev_reg    <= host_wr_cycle;
         if (~conv_ready)
            sample_count_reg <= sample_count_reg + 16'h0001;
      end
   end

   // rising range flag, each new word, start of any decoded host write cycle
   assign ev_set[`ABG_EV_RANGE]   = conv_oor & ~oor_prev_reg;
   assign ev_set[`ABG_EV_READY]   = ~conv_ready;
   assign ev_set[`ABG_EV_HOSTRST] = host_wr_cycle & ~wr_prev_reg;

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   assign ev_clear = (reg_wr && reg_addr == `ABG_REG_STATUS) ?
                     reg_wdata[`ABG_EV_W-1:0] : {`ABG_EV_W{1'b0}};

   // set beats a write-one clear landing in the same cycle
   always @* begin
      status_next = (status_reg & ~ev_clear) | ev_set;
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_reg  <= {`ABG_EV_W{1'b0}};
         mask_reg    <= `ABG_MASK_RESET;
         control_reg <= `ABG_CTL_RESET;
      end else begin
         status_reg <= status_next;
         if (reg_wr && reg_addr == `ABG_REG_MASK)
            mask_reg <= reg_wdata[`ABG_EV_W-1:0];
         if (reg_wr && reg_addr == `ABG_REG_CONTROL)
            control_reg <= reg_wdata[1:0];
         else
            control_reg[`ABG_CTL_LAMPCLR] <= 1'b0;
      end
   end

   // reads answer one cycle later; unmapped addresses read zero
   always @* begin
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `ABG_REG_STATUS: begin
               rdata_next[`ABG_EV_W-1:0] = status_reg;
               rdata_next[8]             = range_hold_flipflop;
               rdata_next[9]             = converter_sync_n;
            end
            `ABG_REG_MASK: begin
               rdata_next[`ABG_EV_W-1:0] = mask_reg;
            end
            `ABG_REG_SAMPLE: begin
               rdata_next[DATA_W-1:0] = conv_word;
               rdata_next[31:16]      = sample_count_reg;
            end
            `ABG_REG_CONTROL: begin
               rdata_next[1:0] = control_reg;
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
         irq       <= 1'b0;
      end else begin
         reg_rdata <= rdata_next;
         irq       <= |(status_next & mask_reg);
      end
   end

endmodule

// *** verif/abg_glue_sva.sv ***
// concurrent checks on the ports of the board host glue
`timescale 1ns/100ps
`include "abg_map.vh"
module abg_glue_sva #(
   parameter IN_W   = 18,
   parameter DATA_W = 16,
   parameter PERIOD = 1
) (
   input wire                   clk,
   input wire                   sys_rst,
   input wire signed [IN_W-1:0] analog_code,
   input wire                   reset_source_jumper,
   input wire                   ready_polarity_jumper,
   input wire [1:0]             base_select_jumpers,
   input wire                   manual_reset_button,
   input wire                   host_addr_a2,
   input wire                   host_addr_a3,
   input wire                   host_space_enable,
   input wire                   host_rd,
   input wire                   host_wr,
   input wire                   reg_wr,
   input wire                   reg_rd,
   input wire [31:0]            reg_rdata,
   input wire [DATA_W-1:0]      sample_data,
   input wire                   host_read_cycle,
   input wire                   range_indicator_lamp,
   input wire                   ready_interrupt_out,
   input wire                   converter_sync_n,
   input wire                   irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire sel = host_space_enable & (host_addr_a2 == ~base_select_jumpers[0])
      & (host_addr_a3 == ~base_select_jumpers[1]);
   wire oor = analog_code > `ABG_FS_POS || analog_code < `ABG_FS_NEG;
   // any strobe that might clear the lamp; a wide net keeps it safe
   wire quiet = !manual_reset_button && !host_wr && !reg_wr;

   AST_RD_CYCLE: assert property (
      sel && host_rd |=> host_read_cycle) else $error("no read cycle");
   AST_RD_NONE: assert property (
      !(sel && host_rd) |=> !host_read_cycle) else $error("stray read");
   AST_HOST_RST: assert property (
      reset_source_jumper && sel && host_wr |=> !converter_sync_n)
      else $error("host write did not reset converter");
   AST_BTN_RST: assert property (
      !reset_source_jumper && manual_reset_button
      |-> ##[1:2] !converter_sync_n) else $error("button reset lost");
   AST_READY_POL: assert property (
      !converter_sync_n
      |=> ready_interrupt_out == !$past(ready_polarity_jumper))
      else $error("ready polarity wrong in reset");
   AST_DATA_LOW: assert property (
      !converter_sync_n [*3] |-> sample_data == '0)
      else $error("data not low in reset");
   AST_LAMP_SET: assert property (
      (oor && converter_sync_n) [*3] |-> ##[1:3] range_indicator_lamp)
      else $error("lamp not lit");
   AST_LAMP_HOLD: assert property (
      quiet [*3] ##0 range_indicator_lamp |=> range_indicator_lamp)
      else $error("lamp dropped without clear");
   AST_RDATA_IDLE: assert property (
      !reg_rd |=> reg_rdata == 32'h0) else $error("read data not idle");

   COV_RD: cover property (host_read_cycle);
   COV_LAMP: cover property ($rose(range_indicator_lamp));
   COV_IRQ: cover property ($fell(irq));
endmodule

bind abg_board_glue abg_glue_sva #(.IN_W(IN_W), .DATA_W(DATA_W),
   .PERIOD(PERIOD)) u_sva (.*);

// *** verif/abg_host_model.sv ***
// host bus model: address lines, space enable and strobes
`timescale 1ns/100ps
module abg_host_model (
   input  wire clk,
   output wire host_addr_a2,
   output wire host_addr_a3,
   output wire host_space_enable,
   output wire host_rd,
   output wire host_wr
);
   reg [4:0] bus = 5'h18;
   assign {host_addr_a2, host_addr_a3, host_space_enable,
      host_rd, host_wr} = bus;
   // after release the address lines flip, so a stale address is
   // never mistaken for one still held
   task automatic cycle(input logic a2, a3, en, rd, wr, input int n);
      @(posedge clk);
      bus <= {a2, a3, en, rd, wr};
      repeat (n) @(posedge clk);
      bus <= {~a2, ~a3, 3'h0};
   endtask
endmodule

// *** verif/abg_board_glue_tb_top.sv ***
// self-checking bench for the board host glue
`timescale 1ns/100ps
module abg_board_glue_tb_top;
   logic               clk = 1'b0, sys_rst = 1'b1;
   logic signed [17:0] analog_code = 18'sh0;
   logic               reset_source_jumper = 1'b0;
   logic               ready_polarity_jumper = 1'b0;
   logic [1:0]         base_select_jumpers = 2'h0;
   logic               manual_reset_button = 1'b0, reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [3:0]         reg_addr = 4'h0;
   logic [31:0]        reg_wdata = 32'h0;
   wire                host_addr_a2, host_addr_a3, host_space_enable;
   wire                host_rd, host_wr, host_read_cycle, irq;
   wire                range_indicator_lamp, ready_interrupt_out;
   wire                converter_sync_n;
   wire [31:0]         reg_rdata;
   wire [15:0]         sample_data;
   int                 error_cnt = 0, checked = 0, cyc = 0;

   always #50 clk = ~clk;
   abg_board_glue dut (.*);
   abg_host_model host (.*);

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_data;
      logic [31:0] v;
      @(posedge clk) analog_code <= 18'sh01234;
      tick(5);
      chk(sample_data, 16'h1234);
      chk(ready_interrupt_out, 0);
      @(posedge clk) {analog_code, ready_polarity_jumper} <= 19'h7ffff;
      tick(4);
      chk(sample_data, 16'hffff);
      chk(ready_interrupt_out, 1);
      rd_reg(4'h8, v);
      chk(v[15:0], 16'hffff);
      $display("data test done");
   endtask
   task automatic t_decode;
      logic [1:0] a;
      for (int j = 0; j < 4; j++) begin
         for (int k = 0; k < 4; k++) begin
            a = k[1:0];
            @(posedge clk) base_select_jumpers <= j[1:0];
            host.cycle(a[0], a[1], 1'b1, 1'b1, 1'b0, 1);
            #1 chk(host_read_cycle, a == ~j[1:0]);
         end
      end
      host.cycle(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1);
      #1 chk(host_read_cycle, 0);
      $display("decode test done");
   endtask
   task automatic t_lamp;
      @(posedge clk) analog_code <= 18'sh08000;
      tick(4);
      @(posedge clk) analog_code <= 18'sh0;
      tick(10);
      chk(range_indicator_lamp, 1);
      @(posedge clk) manual_reset_button <= 1'b1;
      tick(3);
      chk(converter_sync_n, 0);
      chk(sample_data, 0);
      @(posedge clk) manual_reset_button <= 1'b0;
      tick(4);
      chk(range_indicator_lamp, 0);
      chk(converter_sync_n, 1);
      @(posedge clk) {analog_code, reset_source_jumper} <= 19'h70001;
      tick(4);
      @(posedge clk) {analog_code, manual_reset_button} <= 19'h1;
      tick(4);
      chk(range_indicator_lamp, 1);
      chk(converter_sync_n, 1);
      @(posedge clk) {manual_reset_button, base_select_jumpers} <= 3'h0;
      host.cycle(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 3);
      #1 chk(converter_sync_n, 0);
      chk(ready_interrupt_out, 0);
      chk(range_indicator_lamp, 0);
      tick(3);
      chk(converter_sync_n, 1);
      $display("lamp and reset test done");
   endtask
   task automatic t_irq;
      logic [31:0] v;
      // range, word and host reset events are all pending from t_lamp
      rd_reg(4'h0, v);
      chk(v, 32'h0000_0207);
      wr_reg(4'h4, 32'h1);
      wr_reg(4'h0, 32'h7);
      tick(2);
      chk(irq, 0);
      @(posedge clk) analog_code <= 18'sh08000;
      tick(3);
      @(posedge clk) analog_code <= 18'sh0;
      tick(3);
      chk(irq, 1);
      wr_reg(4'h4, 32'h0);
      tick(2);
      chk(irq, 0);
      wr_reg(4'h4, 32'h1);
      wr_reg(4'h0, 32'h1);
      tick(2);
      chk(irq, 0);
      wr_reg(4'h2, 32'hffffffff);
      rd_reg(4'h2, v);
      chk(v, 0);
      rd_reg(4'h4, v);
      chk(v, 1);
      $display("interrupt test done");
   endtask
   task automatic t_ctrl;
      @(posedge clk) analog_code <= 18'sh08000;
      tick(3);
      @(posedge clk) analog_code <= 18'sh0;
      // forced reset must not touch the lamp, only the converter
      wr_reg(4'hc, 32'h2);
      tick(1);
      chk(converter_sync_n, 0);
      chk(range_indicator_lamp, 1);
      wr_reg(4'hc, 32'h1);
      tick(2);
      chk(range_indicator_lamp, 0);
      chk(converter_sync_n, 1);
      $display("control test done");
   endtask

   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      tick(1);
      chk(ready_interrupt_out, 1);
      chk(converter_sync_n, 0);
      @(posedge clk) sys_rst <= 1'b0;
      t_data();
      t_decode();
      t_lamp();
      t_irq();
      t_ctrl();
      stop_test();
   end
endmodule
